// ---- src/pmx_pkg.sv ----
// pmx_pkg: register map, reset values and pin routing table of the pin mux.
// assumes a 32-bit classic Wishbone bus and a 100 MHz peripheral clock.
package pmx_pkg;

  localparam int unsigned REG_NUM    = 10;
  localparam int unsigned PIN_NUM    = 16;
  localparam int unsigned ENC_NUM    = 4;
  localparam int unsigned ADR_W      = 6;

  // register byte offsets
  localparam logic [5:0] OFS_SEL0    = 6'h00;
  localparam logic [5:0] OFS_SEL1    = 6'h04;
  localparam logic [5:0] OFS_SEL2    = 6'h08;
  localparam logic [5:0] OFS_SEL3    = 6'h0c;
  localparam logic [5:0] OFS_SEL4    = 6'h10;
  localparam logic [5:0] OFS_SEL5    = 6'h14;
  localparam logic [5:0] OFS_SEL6    = 6'h18;
  localparam logic [5:0] OFS_FILT    = 6'h20;
  localparam logic [5:0] OFS_DISSRC  = 6'h24;

  // word index 7 holds nothing
  localparam logic [REG_NUM-1:0] REG_VALID = 10'h37f;

  localparam logic [31:0] REG_RESET [REG_NUM] = '{
    32'h0000_0100, 32'h0101_0101, 32'h0001_0101, 32'h0101_0001,
    32'h0001_0101, 32'h0000_0100, 32'h0000_0100, 32'h0000_0000,
    32'h0101_0101, 32'h0000_0001};

  localparam int unsigned IDX_FILT   = 8;
  localparam int unsigned IDX_DISSRC = 9;

  // per pin: selection register index, byte lane, third option present
  localparam int unsigned PIN_REG  [PIN_NUM] = '{0, 1, 1, 1, 1, 2, 2, 2,
                                                  6, 3, 4, 5, 3, 4, 3, 4};
  localparam int unsigned PIN_BYTE [PIN_NUM] = '{1, 0, 1, 2, 3, 0, 1, 2,
                                                  1, 0, 1, 1, 2, 0, 3, 2};
  localparam logic [PIN_NUM-1:0] PIN_HAS3  = 16'h0b40;

  // select byte codes
  localparam logic [7:0] SEL_DEFAULT = 8'h01;
  localparam logic [7:0] SEL_OPT2    = 8'h02;
  localparam logic [7:0] SEL_OPT3    = 8'h04;

  // filter / source control bit positions inside a byte
  localparam int unsigned BIT_SYNC   = 0;
  localparam int unsigned BIT_QUAL   = 1;

  // qualification counter
  localparam int unsigned QUAL_W     = 6;
  localparam logic [QUAL_W-1:0] QUAL_LAST = 6'h3f;

  typedef enum logic [1:0] {
    PMX_SRC_DEFAULT,
    PMX_SRC_OPT2,
    PMX_SRC_OPT3
  } pmx_src_type;

endpackage

// ---- src/pmx_pin_mux.sv ----
// pmx_pin_mux: output pin multiplexer, input fan-out, encoder input
// qualification and timer pin-disable source selection.
// assumes classic Wishbone on CLK_I, PRIV_I valid with every request, pads
// and encoder signals asynchronous to CLK_I.
// How it works
// - reset puts every pin on its default function
// - one set bit per byte picks function
// - each used byte independently selects one pin
// - several bits set in byte give default
// - all-zero register returns pins to default
// - unprivileged writes refused with bus error
// - mux steers only output value and enable
// - pad input reaches all modules regardless
// - port A line 7 default bit resets set
// - phase A sync bit gives two-flop sync
// - phase A qualify bit alone adds 6-bit counter
// - phase A both bits zero means sync
// - phase B same scheme on bits 8,9
// - index same scheme on bits 16,17
// - strobe same scheme on bits 24,25
// - source bit 0 routes port A line 5 directly
// - source bit 1 alone routes inverted synced encoder error
// - both source bits zero means direct port
module pmx_pin_mux
  import pmx_pkg::*;
(
  input  logic                 CLK_I,          // peripheral clock
  input  logic                 RESETN_I,       // synchronous reset, active low
  input  logic                 CE_I,           // clock enable, freezes state
  input  logic                 CYC_I,          // wishbone cycle
  input  logic                 STB_I,          // wishbone strobe
  input  logic                 WE_I,           // wishbone write
  input  logic [ADR_W-1:0]     ADR_I,          // wishbone byte address
  input  logic [3:0]           SEL_I,          // wishbone byte enables
  input  logic [31:0]          DAT_I,          // wishbone write data
  input  logic                 PRIV_I,         // request made in privileged mode
  output logic [31:0]          DAT_O,          // wishbone read data
  output logic                 ACK_O,          // wishbone acknowledge
  output logic                 ERR_O,          // wishbone error
  input  logic [PIN_NUM-1:0]   DEF_OUT_I,      // default function output values
  input  logic [PIN_NUM-1:0]   DEF_OE_I,       // default function output enables
  input  logic [PIN_NUM-1:0]   OPT2_OUT_I,     // option two output values
  input  logic [PIN_NUM-1:0]   OPT2_OE_I,      // option two output enables
  input  logic [PIN_NUM-1:0]   OPT3_OUT_I,     // option three output values
  input  logic [PIN_NUM-1:0]   OPT3_OE_I,      // option three output enables
  output logic [PIN_NUM-1:0]   PAD_OUT_O,      // pad output value
  output logic [PIN_NUM-1:0]   PAD_OE_O,       // pad output enable
  input  logic [PIN_NUM-1:0]   PAD_IN_I,       // pad input level
  output logic [PIN_NUM-1:0]   PIN_IN_O,       // synced pad input to all modules
  input  logic [ENC_NUM-1:0]   ENC_IN_I,       // encoder phase a, b, index, strobe
  output logic [ENC_NUM-1:0]   ENC_OUT_O,      // encoder inputs after filter
  input  logic                 PORT_A_LINE_5_I, // port A line 5 level
  input  logic                 ENC_ERR_I,      // encoder error, active high
  output logic                 TIMER_PIN_DISABLE_IN_O // timer pin-disable input
);

  // ---------------- bus slave ----------------
  logic [31:0]             regs_q [REG_NUM];
  logic                    ack_q;
  logic                    err_q;
  logic [31:0]             dat_q;
  logic [3:0]              adr_idx;
  logic                    bus_req;
  logic                    adr_hit;
  logic                    wr_refused;
  logic                    commit_wr;
  logic [31:0]             wr_mask;
  logic [31:0]             rd_word;

  assign bus_req    = CYC_I & STB_I;
  assign adr_idx    = ADR_I[5:2];
  assign adr_hit    = (adr_idx < 4'(REG_NUM)) && REG_VALID[adr_idx];
  // unprivileged write is refused before it can touch a selector
  assign wr_refused = WE_I & ~PRIV_I;
  // write lands on the edge at which the master samples ack
  assign commit_wr  = bus_req & ack_q & WE_I & adr_hit;
  assign wr_mask    = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign rd_word    = adr_hit ? regs_q[adr_idx] : 32'h0000_0000;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (CE_I) begin
      ack_q <= bus_req & ~ack_q & ~err_q & ~wr_refused;
      err_q <= bus_req & ~ack_q & ~err_q & wr_refused;
      dat_q <= rd_word;
    end
  end

  assign ACK_O = ack_q;
  assign ERR_O = err_q;
  assign DAT_O = dat_q;

  // register file; reserved bits are stored as written
  genvar r;
  generate
    for (r = 0; r < REG_NUM; r++) begin : g_reg
      always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
          regs_q[r] <= REG_RESET[r];
        end else if (CE_I && commit_wr && adr_idx == 4'(r) && REG_VALID[r]) begin
          regs_q[r] <= (regs_q[r] & ~wr_mask) | (DAT_I & wr_mask);
        end
      end
    end
  endgenerate

  // ---------------- output multiplexing ----------------
  // single hot code picks option, anything else falls back to default
  function automatic pmx_src_type pick_src(input logic [7:0] sel, input logic has3);
    pmx_src_type src;
    src = PMX_SRC_DEFAULT;
    case (sel)
      SEL_OPT2: src = PMX_SRC_OPT2;
      SEL_OPT3: src = has3 ? PMX_SRC_OPT3 : PMX_SRC_DEFAULT;
      default:  src = PMX_SRC_DEFAULT;
    endcase
    return src;
  endfunction

  logic [PIN_NUM-1:0] pad_out_q;
  logic [PIN_NUM-1:0] pad_oe_q;
  logic [PIN_NUM-1:0] in_s1_q;
  logic [PIN_NUM-1:0] in_s2_q;
  logic [7:0]         pin_sel [PIN_NUM];
  pmx_src_type        pin_src [PIN_NUM];

  genvar p;
  generate
    for (p = 0; p < PIN_NUM; p++) begin : g_pin
      // each pin owns exactly one byte lane
      assign pin_sel[p] = regs_q[PIN_REG[p]][PIN_BYTE[p]*8 +: 8];
      assign pin_src[p] = pick_src(pin_sel[p], PIN_HAS3[p]);

      // only the output path is switched
      always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
          pad_out_q[p] <= 1'b0;
          pad_oe_q[p]  <= 1'b0;
        end else if (CE_I) begin
          case (pin_src[p])
            PMX_SRC_OPT2: begin
              pad_out_q[p] <= OPT2_OUT_I[p];
              pad_oe_q[p]  <= OPT2_OE_I[p];
            end
            PMX_SRC_OPT3: begin
              pad_out_q[p] <= OPT3_OUT_I[p];
              pad_oe_q[p]  <= OPT3_OE_I[p];
            end
            default: begin
              pad_out_q[p] <= DEF_OUT_I[p];
              pad_oe_q[p]  <= DEF_OE_I[p];
            end
          endcase
        end
      end
    end
  endgenerate

  assign PAD_OUT_O = pad_out_q;
  assign PAD_OE_O  = pad_oe_q;

  // input fan-out: no input mux, every module sees the same level
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end else if (CE_I) begin
      in_s1_q <= PAD_IN_I;
      in_s2_q <= in_s1_q;
    end
  end

  assign PIN_IN_O = in_s2_q;

  // ---------------- encoder input qualification ----------------
  logic [ENC_NUM-1:0] enc_s1_q;
  logic [ENC_NUM-1:0] enc_s2_q;
  logic [ENC_NUM-1:0] enc_filt_q;
  logic [ENC_NUM-1:0] enc_qual;
  logic [QUAL_W-1:0]  enc_cnt_q [ENC_NUM];

  genvar e;
  generate
    for (e = 0; e < ENC_NUM; e++) begin : g_enc
      // qualify only when sync bit clear and qualify bit set
      assign enc_qual[e] = ~regs_q[IDX_FILT][e*8 + BIT_SYNC]
                         &  regs_q[IDX_FILT][e*8 + BIT_QUAL];

      always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
          enc_s1_q[e]   <= 1'b0;
          enc_s2_q[e]   <= 1'b0;
          enc_filt_q[e] <= 1'b0;
          enc_cnt_q[e]  <= '0;
        end else if (CE_I) begin
          enc_s1_q[e] <= ENC_IN_I[e];
          enc_s2_q[e] <= enc_s1_q[e];
          // counter restarts whenever the input matches the output again
          if (enc_s2_q[e] == enc_filt_q[e]) begin
            enc_cnt_q[e] <= '0;
          end else if (enc_cnt_q[e] == QUAL_LAST) begin
            enc_filt_q[e] <= enc_s2_q[e];
            enc_cnt_q[e]  <= '0;
          end else begin
            enc_cnt_q[e] <= enc_cnt_q[e] + 6'h01;
          end
        end
      end

      // illegal 00 code behaves as sync only
      assign ENC_OUT_O[e] = enc_qual[e] ? enc_filt_q[e] : enc_s2_q[e];
    end
  endgenerate

  // ---------------- timer pin-disable source ----------------
  logic err_s1_q;
  logic err_s2_q;
  logic dis_from_err;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      err_s1_q <= 1'b1;
      err_s2_q <= 1'b1;
    end else if (CE_I) begin
      err_s1_q <= ~ENC_ERR_I;
      err_s2_q <= err_s1_q;
    end
  end

  assign dis_from_err = ~regs_q[IDX_DISSRC][BIT_SYNC] & regs_q[IDX_DISSRC][BIT_QUAL];
  // direct path is unsynchronised by intent: pin-disable must act at once
  assign TIMER_PIN_DISABLE_IN_O = dis_from_err ? err_s2_q
                                               : PORT_A_LINE_5_I;

  // ---------------- assertions ----------------
  // helper history: enable seen and reset clear at the two previous edges,
  // so two-flop checks never look back across a reset or a freeze
  logic [1:0] live_q;
  logic       two_live;
  logic [6:0] run_q;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      live_q <= 2'b00;
    end else begin
      live_q <= {live_q[0], CE_I};
    end
  end

  assign two_live = live_q[1] & live_q[0];

  // own count of consecutive edges at which phase A disagreed with its filtered level
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      run_q <= 7'h00;
    end else if (CE_I) begin
      run_q <= (enc_s2_q[0] != enc_filt_q[0]) ? run_q + 7'h01 : 7'h00;
    end
  end

  sequence s_full_write;
    CE_I && commit_wr && SEL_I == 4'hf && adr_idx == 4'(IDX_DISSRC);
  endsequence

  sequence s_nopriv_write;
    CE_I && bus_req && WE_I && !PRIV_I && !ack_q && !err_q;
  endsequence

  sequence s_refused;
    err_q && !ack_q;
  endsequence

  a_reset_defaults: assert property (@(posedge CLK_I)
    !RESETN_I |=> (regs_q[2] == 32'h0001_0101) && (regs_q[8] == 32'h0101_0101)
                  && (regs_q[9] == 32'h0000_0001))
    else $error("selector registers not at reset defaults");

  a_line7_default: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    $rose(RESETN_I) |-> regs_q[2][16])
    else $error("port A line 7 default bit not set after reset");

  a_priv_error: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    s_nopriv_write |=> s_refused)
    else $error("unprivileged write not answered with error");

  a_priv_no_store: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    s_nopriv_write |=> ##1 (regs_q[adr_idx] == $past(regs_q[adr_idx], 2)))
    else $error("unprivileged write changed a register");

  a_bad_byte: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && pin_sel[6] == 8'h03) |=> pad_out_q[6] == $past(DEF_OUT_I[6]))
    else $error("multi-bit select did not give default function");

  a_opt2_route: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && pin_sel[7] == SEL_OPT2) |=> pad_oe_q[7] == $past(OPT2_OE_I[7]))
    else $error("option two not routed to pin");

  a_input_fanout: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    two_live |-> PIN_IN_O == $past(PAD_IN_I, 2))
    else $error("pad input not delivered after two flops");

  a_enc_sync: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (two_live && !enc_qual[0]) |-> ENC_OUT_O[0] == $past(ENC_IN_I[0], 2))
    else $error("phase A sync path is not two flops");

  a_enc_b_sync: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (two_live && !enc_qual[1]) |-> ENC_OUT_O[1] == $past(ENC_IN_I[1], 2))
    else $error("phase B sync path is not two flops");

  a_enc_idx_sync: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (two_live && !enc_qual[2]) |-> ENC_OUT_O[2] == $past(ENC_IN_I[2], 2))
    else $error("index sync path is not two flops");

  a_enc_stb_sync: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (two_live && !enc_qual[3]) |-> ENC_OUT_O[3] == $past(ENC_IN_I[3], 2))
    else $error("strobe sync path is not two flops");

  a_qual_count: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    $changed(enc_filt_q[0]) |-> $past(run_q) == 7'h3f)
    else $error("phase A qualifier did not wait 64 cycles");

  a_ack_pulse: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (ack_q && CE_I) |=> !ack_q)
    else $error("acknowledge longer than one cycle");

  a_err_pulse: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (err_q && CE_I) |=> !err_q)
    else $error("error response longer than one cycle");

  a_priv_read_ok: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && bus_req && !WE_I && !PRIV_I && !ack_q && !err_q) |=> ack_q && !err_q)
    else $error("unprivileged read was refused");

  a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && bus_req && !WE_I && !adr_hit && !ack_q && !err_q) |=> ack_q && DAT_O == 32'h0)
    else $error("unmapped read not answered with zero");

  a_write_lands: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    s_full_write |=> regs_q[IDX_DISSRC] == $past(DAT_I))
    else $error("acknowledged write did not land");

  a_allzero_dflt: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && regs_q[3] == 32'h0) |=> pad_out_q[9] == $past(DEF_OUT_I[9])
      && pad_out_q[12] == $past(DEF_OUT_I[12]) && pad_out_q[14] == $past(DEF_OUT_I[14]))
    else $error("all-zero register did not give default functions");

  a_opt3_route: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && pin_sel[9] == SEL_OPT3) |=> pad_out_q[9] == $past(OPT3_OUT_I[9])
      && pad_oe_q[9] == $past(OPT3_OE_I[9]))
    else $error("option three not routed to pin");

  a_no_opt3: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && pin_sel[0] == SEL_OPT3) |=> pad_out_q[0] == $past(DEF_OUT_I[0]))
    else $error("missing option three did not give default");

  a_dflt_route: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && pin_src[1] == PMX_SRC_DEFAULT) |=> pad_out_q[1] == $past(DEF_OUT_I[1])
      && pad_oe_q[1] == $past(DEF_OE_I[1]))
    else $error("default function not routed to pin");

  a_opt2_value: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && pin_sel[13] == SEL_OPT2) |=> pad_out_q[13] == $past(OPT2_OUT_I[13]))
    else $error("option two value not routed to pin");

  a_qual_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    $changed(enc_filt_q[1]) |-> $past(enc_cnt_q[1]) == QUAL_LAST)
    else $error("qualified output changed before 64 cycles");

  a_dis_direct: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !dis_from_err |-> TIMER_PIN_DISABLE_IN_O == PORT_A_LINE_5_I)
    else $error("pin-disable not taken from port A line 5");

  a_dis_error: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (dis_from_err && two_live) |-> TIMER_PIN_DISABLE_IN_O == !$past(ENC_ERR_I, 2))
    else $error("pin-disable not inverted synced encoder error");

endmodule

// ---- dv/pmx_periph_model.sv ----
// pmx_periph_model: function outputs of the peripherals and the pad wiring.
// assumes an undriven pad takes the board level that the bench supplies.
module pmx_periph_model
  import pmx_pkg::*;
(
  input  wire logic [PIN_NUM-1:0] pad_out_i,  // pad value from the mux
  input  wire logic [PIN_NUM-1:0] pad_oe_i,   // pad enable from the mux
  input  wire logic [PIN_NUM-1:0] ext_i,      // board level when undriven
  output logic      [PIN_NUM-1:0] def_out_o,  // default function values
  output logic      [PIN_NUM-1:0] def_oe_o,   // default function enables
  output logic      [PIN_NUM-1:0] opt2_out_o, // option two values
  output logic      [PIN_NUM-1:0] opt2_oe_o,  // option two enables
  output logic      [PIN_NUM-1:0] opt3_out_o, // option three values
  output logic      [PIN_NUM-1:0] opt3_oe_o,  // option three enables
  output logic      [PIN_NUM-1:0] pad_in_o    // level seen on each pad
);
  // distinct patterns, so a wrong pick shows on some pin
  assign def_out_o  = 16'h00ff;
  assign def_oe_o   = 16'hf0f0;
  assign opt2_out_o = 16'h0f0f;
  assign opt2_oe_o  = 16'h3c3c;
  assign opt3_out_o = 16'h3333;
  assign opt3_oe_o  = 16'h5a5a;
  // one input path whatever drives the pad
  assign pad_in_o   = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// ---- dv/test_pmx_pin_mux.sv ----
// test_pmx_pin_mux: registers, pad mux, input fan-out, encoder filter, disable source.
// assumes the peripheral model is compiled first; CE_I high except in the freeze test.
module test_pmx_pin_mux;
  import pmx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, priv = 0, pa5 = 0, eerr = 0, e, ce = 1;
  logic [5:0]         adr = '0;
  logic [3:0]         sel = '0, enc_in = '0, enc_out;
  logic [31:0]        dat = '0, dat_o, d;
  logic               ack, err, tdis;
  logic [PIN_NUM-1:0] d_o, d_e, o2, e2, o3, e3, p_o, p_e, p_i, pin_in, ext = 16'h1234;
  logic [31:0]        sh [REG_NUM];
  logic [7:0]         codes [5] = '{8'h02, 8'h04, 8'h03, 8'h00, 8'h01};
  int                 error_cnt = 0, total_checks = 0;
  always #5 clk = ~clk;

  pmx_pin_mux dut_u (.CLK_I(clk), .RESETN_I(rstn), .CE_I(ce), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .PRIV_I(priv), .DAT_O(dat_o),
    .ACK_O(ack), .ERR_O(err), .DEF_OUT_I(d_o), .DEF_OE_I(d_e), .OPT2_OUT_I(o2),
    .OPT2_OE_I(e2), .OPT3_OUT_I(o3), .OPT3_OE_I(e3), .PAD_OUT_O(p_o), .PAD_OE_O(p_e),
    .PAD_IN_I(p_i), .PIN_IN_O(pin_in), .ENC_IN_I(enc_in), .ENC_OUT_O(enc_out),
    .PORT_A_LINE_5_I(pa5), .ENC_ERR_I(eerr), .TIMER_PIN_DISABLE_IN_O(tdis));
  pmx_periph_model far_u (.pad_out_i(p_o), .pad_oe_i(p_e), .ext_i(ext), .def_out_o(d_o),
    .def_oe_o(d_e), .opt2_out_o(o2), .opt2_oe_o(e2), .opt3_out_o(o3), .opt3_oe_o(e3),
    .pad_in_o(p_i));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] a, input logic [3:0] s,
                    input logic [31:0] wd, input logic p, output logic [31:0] rd,
                    output logic er);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= wd;
    priv <= p;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    rd = dat_o;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      $display("[ERR] %0t bus answer missing", $time);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] wd, input logic [3:0] s);
    logic [31:0] r;
    logic er;
    wb(1'b1, a, s, wd, 1'b1, r, er);
    chk(er, 1'b0, "write refused");
    if (a[5:2] < REG_NUM && REG_VALID[a[5:2]])
      for (int b = 0; b < 4; b++) if (s[b]) sh[a[5:2]][b*8 +: 8] = wd[b*8 +: 8];
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic er;
    wb(1'b0, a, 4'hf, 32'h0, 1'b1, r, er);
    chk(r, exp, "read data");
  endtask

  // expected pad from shadow selection; odd codes fall back to default
  task automatic check_pads();
    logic [PIN_NUM-1:0] eo, ee;
    logic [7:0] b;
    ext <= ~ext;
    repeat (4) @(posedge clk);
    for (int p = 0; p < PIN_NUM; p++) begin
      b = sh[PIN_REG[p]][PIN_BYTE[p]*8 +: 8];
      {eo[p], ee[p]} = (b == SEL_OPT2) ? {o2[p], e2[p]} :
        (b == SEL_OPT3 && PIN_HAS3[p]) ? {o3[p], e3[p]} : {d_o[p], d_e[p]};
    end
    chk(p_o, eo, "pad value");
    chk(p_e, ee, "pad enable");
    chk(pin_in, p_i, "pin fan-out");
  endtask

  task automatic enc_mode(input logic [1:0] code, input logic qual);
    logic [3:0] v, nv;
    wr(OFS_FILT, {4{6'h00, code}}, 4'hf);
    v = ~enc_out;
    nv = ~v;
    enc_in <= v;
    if (qual) begin
      repeat (40) @(posedge clk);
      chk(enc_out, nv, "qualifier early");
      enc_in <= nv;
      @(posedge clk);
      enc_in <= v;
      repeat (60) @(posedge clk);
      chk(enc_out, nv, "qualifier restart");
      repeat (10) @(posedge clk);
    end else begin
      repeat (3) @(posedge clk);
    end
    chk(enc_out, v, "encoder level");
  endtask

  task automatic dis_mode(input logic [1:0] code);
    wr(OFS_DISSRC, {30'h0, code}, 4'hf);
    for (int i = 0; i < 2; i++) begin
      pa5 <= i[0];
      eerr <= i[0];
      repeat (3) @(posedge clk);
      chk(tdis, (code == 2'b10) ? !eerr : pa5, "disable source");
    end
  endtask

  initial begin
    for (int i = 0; i < REG_NUM; i++) sh[i] = REG_RESET[i];
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < REG_NUM; i++) rd(6'(i * 4), sh[i]);
    rd(6'h28, 32'h0);
    check_pads();
    wr(OFS_SEL2, 32'h0002_0000, 4'h4);
    check_pads();
    foreach (codes[c]) begin
      for (int r = 0; r < 7; r++) begin
        d = '0;
        for (int p = 0; p < PIN_NUM; p++) if (PIN_REG[p] == r) d[PIN_BYTE[p]*8 +: 8] = codes[c];
        wr(6'(r * 4), d, 4'hf);
      end
      check_pads();
    end
    wb(1'b1, OFS_SEL2, 4'hf, 32'h0002_0202, 1'b0, d, e);
    chk(e, 1'b1, "unprivileged write");
    rd(OFS_SEL2, sh[2]);
    wb(1'b0, OFS_SEL2, 4'hf, 32'h0, 1'b0, d, e);
    chk(e, 1'b0, "unprivileged read");
    chk(d, sh[2], "unprivileged read data");
    wr(6'h1c, 32'hffff_ffff, 4'hf);
    rd(6'h1c, 32'h0);
    enc_mode(2'b01, 1'b0);
    enc_mode(2'b11, 1'b0);
    enc_mode(2'b10, 1'b1);
    enc_mode(2'b00, 1'b0);
    dis_mode(2'b01);
    dis_mode(2'b10);
    dis_mode(2'b00);
    ce <= 1'b0;
    d = 32'(pin_in);
    ext <= ~ext;
    repeat (4) @(posedge clk);
    chk(pin_in, d, "frozen fan-out");
    ce <= 1'b1;
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t run too long", $time);
    wrap_up();
  end
endmodule
